// File: hw/ebi_mux_pkg.sv
package ebi_mux_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 26;
  localparam int HADDR_W = 32;
  // window base nibble of the transfer address
  localparam logic [3:0] CS4_WINDOW = 4'h5;
  localparam logic [3:0] CS5_WINDOW = 4'h6;
  localparam int MODE_LSB = 21;
  localparam int REG_PIN = 22;
  localparam int RNW_PIN = 25;
  localparam logic [2:0] SEL_ATTR = 3'h0;
  localparam logic [2:0] SEL_COMMON = 3'h2;
  localparam logic [2:0] SEL_IO = 3'h4;
  localparam logic [2:0] SEL_IDE = 3'h6;
  localparam logic [2:0] SEL_ALT_IDE = 3'h7;
  localparam logic [1:0] DBW_8 = 2'h0;
  localparam logic [1:0] DBW_16 = 2'h1;
  localparam int PULLUP_W = 16;
  localparam logic [3:0] FLOAT_RESET = 4'h0;

  typedef enum logic [2:0] {
    mode_none_type_e, mode_attr, mode_common, mode_io, mode_ide, mode_alt_ide
  } card_mode_type;

  // strobes as the static controller presents them
  typedef struct packed {
    logic cs4_n;
    logic cs5_n;
    logic read_strobe_n;
    logic write_enable_n;
    logic byte_sel_low;
    logic byte_sel_high;
    logic write_strobe1_n;
    logic write_strobe3_n;
    logic byte_sel_top;
    logic byte_mode;
    logic [1:0] bus_width_field;
  } smc_strobe_type;

  // card-facing pin set
  typedef struct packed {
    logic card_buf_select_0;
    logic card_buf_select_1;
    logic card_enable_low;
    logic card_enable_high;
    logic card_mem_output_enable;
    logic card_mem_write_enable;
    logic card_io_read;
    logic card_io_write;
    logic card_buf_direction;
  } card_pin_type;
endpackage

// File: hw/card_mode_decode.sv
`timescale 1ns/1ps
module card_mode_decode (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ebi_mux_pkg::HADDR_W-1:0] haddr,
  input wire logic slot0_assign,
  input wire logic slot1_assign,
  input wire logic access_start,
  output ebi_mux_pkg::card_mode_type mode_q,
  output logic slot_q
);
  ebi_mux_pkg::card_mode_type mode_d;
  logic hit4;
  logic hit5;
  logic [2:0] sel;

  // (RQ6) slot window hits
  assign hit4 = slot0_assign && haddr[31:28] == ebi_mux_pkg::CS4_WINDOW;
  assign hit5 = slot1_assign && haddr[31:28] == ebi_mux_pkg::CS5_WINDOW;
  assign sel = haddr[ebi_mux_pkg::MODE_LSB+2:ebi_mux_pkg::MODE_LSB];

  // (RQ8) mode decode
  always_comb begin
    mode_d = ebi_mux_pkg::mode_none_type_e;
    if (hit4 || hit5) begin
      case (sel)
        ebi_mux_pkg::SEL_ATTR: mode_d = ebi_mux_pkg::mode_attr;
        ebi_mux_pkg::SEL_COMMON: mode_d = ebi_mux_pkg::mode_common;
        ebi_mux_pkg::SEL_IO: mode_d = ebi_mux_pkg::mode_io;
        ebi_mux_pkg::SEL_IDE: mode_d = ebi_mux_pkg::mode_ide;
        ebi_mux_pkg::SEL_ALT_IDE: mode_d = ebi_mux_pkg::mode_alt_ide;
        default: mode_d = ebi_mux_pkg::mode_none_type_e;
      endcase
    end
  end

  // (RQ20) latch at chip-select assertion
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= ebi_mux_pkg::mode_none_type_e;
      slot_q <= 1'b0;
    end else if (access_start) begin
      mode_q <= mode_d;
      slot_q <= hit5;
    end
  end
endmodule

// File: hw/float_guard.sv
`timescale 1ns/1ps
module float_guard (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic owner_change,
  input wire logic [3:0] float_cycles,
  output logic busy_q
);
  logic [3:0] cnt_q;

  // (RQ3) wait out data float time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= ebi_mux_pkg::FLOAT_RESET;
    end else if (owner_change) begin
      cnt_q <= float_cycles;
    end else if (cnt_q != 4'h0) begin
      cnt_q <= cnt_q - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= owner_change ? (float_cycles != 4'h0) : (cnt_q > 4'h1);
    end
  end
endmodule

// File: hw/ebi_card_support_mux.sv
// Summary of operation
// (RQ1) route data, address and controls to the controller owning the access
// (RQ2) hold address and output controls steady when no access runs
// (RQ3) honour the finishing controller's data float time on ownership change
// (RQ4) dram refresh runs alone and never stalls static accesses; here a static request waits while the dram grant is held
// (RQ5) data pull-ups on D0-D15 on after reset, off when disable bit set
// (RQ6) card logic per slot bit, windows at 0x5000 0000 and 0x6000 0000
// (RQ7) attribute, common, io and ide modes; io16 and ide-select untouched
// (RQ8) address bits 23:21 select the five card modes
// (RQ9) pin A22 is register select except in true ide
// (RQ10) software picks 8-bit width for odd bytes on low lanes
// (RQ11) card enables follow the active chip-select waveform
// (RQ12) 16-bit byte-select: enable high follows upper, low follows lower
// (RQ13) 8-bit common, io, task file: enable high 1, enable low 0
// (RQ14) alternate ide: enable high 0, enable low 1
// (RQ15) idle or unassigned: both card enables high
// (RQ16) io and ide steer strobes to io pins; ide holds output enable low
// (RQ17) assigned chip-select pin carries the card chip select only
// (RQ18) shared strobes and A25 carry card signals only on card accesses
// (RQ19) direction valid whole transfer; buffer select timed as chip select 4
// (RQ20) mode and steering latched at chip-select assertion
`timescale 1ns/1ps
module ebi_card_support_mux #(
  parameter int DATA_W = ebi_mux_pkg::DATA_W,
  parameter int ADDR_W = ebi_mux_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ebi_mux_pkg::HADDR_W-1:0] smc_haddr,
  input wire logic smc_rnw,
  input wire logic [ADDR_W-1:0] smc_addr,
  input wire logic [DATA_W-1:0] smc_wdata,
  input wire logic smc_data_oe,
  input wire ebi_mux_pkg::smc_strobe_type smc_strobe,
  input wire logic [3:0] smc_float_cycles,
  input wire logic smc_busy,
  input wire logic [ADDR_W-1:0] dram_addr,
  input wire logic [DATA_W-1:0] dram_wdata,
  input wire logic dram_data_oe,
  input wire logic dram_busy,
  input wire logic [3:0] dram_float_cycles,
  input wire logic slot0_assign,
  input wire logic slot1_assign,
  input wire logic data_pullup_disable,
  input wire logic [DATA_W-1:0] pin_data_in,
  output logic [DATA_W-1:0] rdata_q,
  output logic [ADDR_W-1:0] pin_addr_q,
  output logic [DATA_W-1:0] pin_data_out_q,
  output logic pin_data_oe_q,
  output logic [ebi_mux_pkg::PULLUP_W-1:0] pullup_en_q,
  output logic chip_select_4_q,
  output logic chip_select_5_q,
  output logic pin_read_q,
  output logic pin_write0_q,
  output logic pin_write1_q,
  output logic pin_write3_q,
  output logic card_enable_low_q,
  output logic card_enable_high_q,
  output logic smc_grant_q,
  output logic dram_grant_q
);
  logic [DATA_W-1:0] data_meta_q;
  logic [DATA_W-1:0] data_sync_q;
  logic cs_any_n;
  logic cs_prev_q;
  logic access_start;
  ebi_mux_pkg::card_mode_type mode_q;
  logic slot_q;
  logic card_act;
  logic [1:0] owner_q;
  logic [1:0] owner_d;
  logic float_busy;
  logic [3:0] float_sel;
  logic ce_low_d;
  logic ce_high_d;
  logic rd_d;
  logic wr0_d;
  logic wr1_d;
  logic wr3_d;
  logic rnw_q;

  localparam logic [1:0] OWN_NONE = 2'h0;
  localparam logic [1:0] OWN_SMC = 2'h1;
  localparam logic [1:0] OWN_DRAM = 2'h2;

  assign cs_any_n = smc_strobe.cs4_n & smc_strobe.cs5_n;
  assign access_start = cs_prev_q & ~cs_any_n;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_any_n;
    end
  end

  card_mode_decode u_decode (
    .clk(clk),
    .arst_n(arst_n),
    .haddr(smc_haddr),
    .slot0_assign(slot0_assign),
    .slot1_assign(slot1_assign),
    .access_start(access_start),
    .mode_q(mode_q),
    .slot_q(slot_q)
  );

  // (RQ7) io16 and ide-select are never driven or sampled
  // previous access mode is ignored while the new one latches
  assign card_act = ~cs_any_n && !access_start && mode_q != ebi_mux_pkg::mode_none_type_e &&
    (slot_q ? ~smc_strobe.cs5_n : ~smc_strobe.cs4_n);

  // (RQ4) refresh and dram traffic stay inside dram grant only
  always_comb begin
    owner_d = owner_q;
    if (smc_busy && !float_busy && owner_q != OWN_DRAM) begin
      owner_d = OWN_SMC;
    end else if (dram_busy && !float_busy && owner_q != OWN_SMC) begin
      owner_d = OWN_DRAM;
    end else if (!smc_busy && owner_q == OWN_SMC) begin
      owner_d = OWN_NONE;
    end else if (!dram_busy && owner_q == OWN_DRAM) begin
      owner_d = OWN_NONE;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      owner_q <= OWN_NONE;
    end else begin
      owner_q <= owner_d;
    end
  end

  assign float_sel = (owner_q == OWN_DRAM) ? dram_float_cycles : smc_float_cycles;

  // (RQ3) float time of the controller that finished
  float_guard u_float (
    .clk(clk),
    .arst_n(arst_n),
    .owner_change(owner_q != OWN_NONE && owner_d == OWN_NONE),
    .float_cycles(float_sel),
    .busy_q(float_busy)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smc_grant_q <= 1'b0;
      dram_grant_q <= 1'b0;
    end else begin
      smc_grant_q <= owner_d == OWN_SMC;
      dram_grant_q <= owner_d == OWN_DRAM;
    end
  end

  // (RQ19) direction held for the whole transfer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rnw_q <= 1'b1;
    end else if (access_start) begin
      rnw_q <= smc_rnw;
    end
  end

  // (RQ1) address routing to owner
  // (RQ2) hold address when idle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_addr_q <= '0;
    end else if (owner_q == OWN_DRAM) begin
      pin_addr_q <= dram_addr;
    end else if (owner_q == OWN_SMC) begin
      pin_addr_q <= smc_addr;
      // (RQ9) register select on A22 outside true ide
      if (card_act && (mode_q == ebi_mux_pkg::mode_ide || mode_q == ebi_mux_pkg::mode_alt_ide)) begin
        pin_addr_q[ebi_mux_pkg::REG_PIN] <= 1'b1;
      end
      // (RQ18) A25 carries card direction
      if (card_act) begin
        pin_addr_q[ebi_mux_pkg::RNW_PIN] <= rnw_q;
      end
    end
  end

  // (RQ1) data routing to owner
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_data_out_q <= '0;
      pin_data_oe_q <= 1'b0;
    end else begin
      pin_data_oe_q <= !float_busy && ((owner_q == OWN_SMC && smc_data_oe) ||
        (owner_q == OWN_DRAM && dram_data_oe));
      if (owner_q == OWN_DRAM) begin
        pin_data_out_q <= dram_wdata;
      end else if (owner_q == OWN_SMC) begin
        pin_data_out_q <= smc_wdata;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_meta_q <= '0;
      data_sync_q <= '0;
      rdata_q <= '0;
    end else begin
      data_meta_q <= pin_data_in;
      data_sync_q <= data_meta_q;
      rdata_q <= data_sync_q;
    end
  end

  // (RQ5) pull-ups on from reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pullup_en_q <= '1;
    end else begin
      pullup_en_q <= {ebi_mux_pkg::PULLUP_W{~data_pullup_disable}};
    end
  end

  // card enable table
  always_comb begin
    ce_high_d = 1'b1;
    ce_low_d = 1'b1;
    if (card_act) begin
      case (mode_q)
        ebi_mux_pkg::mode_attr: begin
          // (RQ12) byte selects
          ce_high_d = smc_strobe.byte_sel_high;
          ce_low_d = smc_strobe.byte_sel_low;
        end
        ebi_mux_pkg::mode_common, ebi_mux_pkg::mode_io, ebi_mux_pkg::mode_ide: begin
          if (smc_strobe.bus_width_field == ebi_mux_pkg::DBW_16 && smc_strobe.byte_mode) begin
            // (RQ12) byte selects
            ce_high_d = smc_strobe.byte_sel_high;
            ce_low_d = smc_strobe.byte_sel_low;
          end else begin
            // (RQ13) odd byte on low lanes
            ce_high_d = 1'b1;
            ce_low_d = 1'b0;
          end
        end
        ebi_mux_pkg::mode_alt_ide: begin
          // (RQ14) alternate ide enables
          ce_high_d = 1'b0;
          ce_low_d = 1'b1;
        end
        default: begin
          // (RQ15) unassigned
          ce_high_d = 1'b1;
          ce_low_d = 1'b1;
        end
      endcase
    end
  end

  // (RQ11) enables track chip select edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      card_enable_low_q <= 1'b1;
      card_enable_high_q <= 1'b1;
    end else begin
      card_enable_low_q <= ce_low_d;
      card_enable_high_q <= ce_high_d;
    end
  end

  // (RQ17) assigned pin carries card buffer select
  // (RQ19) buffer select timed as chip select
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      chip_select_4_q <= 1'b1;
      chip_select_5_q <= 1'b1;
    end else begin
      chip_select_4_q <= slot0_assign ? (smc_strobe.cs4_n | ~card_act) : smc_strobe.cs4_n;
      chip_select_5_q <= slot1_assign ? (smc_strobe.cs5_n | ~card_act) : smc_strobe.cs5_n;
    end
  end

  // (RQ16) strobe steering per mode
  // (RQ18) normal functions off card
  always_comb begin
    rd_d = smc_strobe.read_strobe_n;
    wr0_d = smc_strobe.write_enable_n;
    wr1_d = smc_strobe.byte_mode ? smc_strobe.byte_sel_high : smc_strobe.write_strobe1_n;
    wr3_d = smc_strobe.byte_mode ? smc_strobe.byte_sel_top : smc_strobe.write_strobe3_n;
    if (card_act) begin
      case (mode_q)
        ebi_mux_pkg::mode_attr, ebi_mux_pkg::mode_common: begin
          wr1_d = 1'b1;
          wr3_d = 1'b1;
        end
        ebi_mux_pkg::mode_io: begin
          rd_d = 1'b1;
          wr0_d = 1'b1;
          wr1_d = smc_strobe.read_strobe_n;
          wr3_d = smc_strobe.write_enable_n;
        end
        ebi_mux_pkg::mode_ide, ebi_mux_pkg::mode_alt_ide: begin
          rd_d = 1'b0;
          wr0_d = 1'b1;
          wr1_d = smc_strobe.read_strobe_n;
          wr3_d = smc_strobe.write_enable_n;
        end
        default: begin
          rd_d = smc_strobe.read_strobe_n;
        end
      endcase
    end
  end

  // (RQ2) strobes idle high without access
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_read_q <= 1'b1;
      pin_write0_q <= 1'b1;
      pin_write1_q <= 1'b1;
      pin_write3_q <= 1'b1;
    end else if (owner_q == OWN_SMC) begin
      pin_read_q <= rd_d;
      pin_write0_q <= wr0_d;
      pin_write1_q <= wr1_d;
      pin_write3_q <= wr3_d;
    end else begin
      pin_read_q <= 1'b1;
      pin_write0_q <= 1'b1;
      pin_write1_q <= 1'b1;
      pin_write3_q <= 1'b1;
    end
  end
endmodule

// File: dv/ebi_card_support_mux_monitor.sv
`timescale 1ns/1ps
module ebi_card_support_mux_monitor #(
  parameter int DATA_W = 32,
  parameter int ADDR_W = 26
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire ebi_mux_pkg::smc_strobe_type smc_strobe,
  input wire logic smc_busy,
  input wire logic dram_busy,
  input wire logic data_pullup_disable,
  input wire logic [ADDR_W-1:0] pin_addr_q,
  input wire logic [ebi_mux_pkg::PULLUP_W-1:0] pullup_en_q,
  input wire logic chip_select_4_q,
  input wire logic pin_read_q,
  input wire logic pin_write0_q,
  input wire logic card_enable_low_q,
  input wire logic card_enable_high_q,
  input wire logic smc_grant_q,
  input wire logic dram_grant_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic no_owner;
  assign no_owner = !smc_busy && !dram_busy && !smc_grant_q && !dram_grant_q;
  property p_pullup;
    1'h1 |=> pullup_en_q == {16{!$past(data_pullup_disable)}};
  endproperty
  property p_idle_enables;
    (smc_strobe.cs4_n && smc_strobe.cs5_n) [*3] |-> card_enable_low_q && card_enable_high_q;
  endproperty
  property p_enable_needs_cs;
    !(card_enable_low_q && card_enable_high_q) |-> !$past(smc_strobe.cs4_n, 2) || !$past(smc_strobe.cs5_n, 2);
  endproperty
  property p_cs4_idle;
    smc_strobe.cs4_n |=> chip_select_4_q;
  endproperty
  property p_smc_release;
    !smc_busy |=> !smc_grant_q;
  endproperty
  property p_dram_release;
    !dram_busy |=> !dram_grant_q;
  endproperty
  property p_one_owner;
    !(smc_grant_q && dram_grant_q);
  endproperty
  property p_addr_hold;
    no_owner |=> $stable(pin_addr_q);
  endproperty
  property p_strobe_hold;
    no_owner |=> pin_read_q && pin_write0_q && chip_select_4_q;
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up state wrong");
  a_idle_enables: assert property (p_idle_enables) else $error("card enable low while idle");
  a_enable_needs_cs: assert property (p_enable_needs_cs) else $error("card enable without chip select");
  a_cs4_idle: assert property (p_cs4_idle) else $error("chip select 4 pin low without request");
  a_smc_release: assert property (p_smc_release) else $error("static grant held after busy");
  a_dram_release: assert property (p_dram_release) else $error("dram grant held after busy");
  a_one_owner: assert property (p_one_owner) else $error("two owners at once");
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while idle");
  a_strobe_hold: assert property (p_strobe_hold) else $error("strobe active while idle");
  c_alt_ide: cover property (!card_enable_high_q && card_enable_low_q);
  c_dram_done: cover property (dram_grant_q ##1 !dram_grant_q);
  c_cs4_access: cover property ($fell(chip_select_4_q));
endmodule
bind ebi_card_support_mux ebi_card_support_mux_monitor #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) i_monitor (
  .clk, .arst_n, .smc_strobe, .smc_busy, .dram_busy, .data_pullup_disable, .pin_addr_q, .pullup_en_q,
  .chip_select_4_q, .pin_read_q, .pin_write0_q, .card_enable_low_q, .card_enable_high_q, .smc_grant_q,
  .dram_grant_q);

// File: dv/card_slot_model.sv
`timescale 1ns/1ps
module card_slot_model (
  input wire logic clk,
  input wire logic [25:0] addr,
  input wire logic cs4_n,
  input wire logic cs5_n,
  input wire logic oe,
  input wire logic [15:0] pullup_en,
  output logic [31:0] data
);
  logic [31:0] last_q;
  // released lines: pulled-up low half, upper half keeps toggling
  always_ff @(posedge clk) begin
    if (!oe && !(cs4_n && cs5_n)) begin
      last_q <= {4{addr[7:0] ^ 8'h5A}};
    end else begin
      last_q <= {~last_q[31:16], pullup_en | ~last_q[15:0]};
    end
  end
  assign data = last_q;
endmodule

// File: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clk, arst_n, smc_rnw, smc_data_oe, smc_busy, dram_data_oe, dram_busy, slot0_assign, slot1_assign;
  logic data_pullup_disable, pin_data_oe_q, chip_select_4_q, chip_select_5_q, pin_read_q, pin_write0_q;
  logic pin_write1_q, pin_write3_q, card_enable_low_q, card_enable_high_q, smc_grant_q, dram_grant_q;
  logic [31:0] smc_haddr, smc_wdata, dram_wdata, pin_data_in, rdata_q, pin_data_out_q;
  logic [25:0] smc_addr, dram_addr, pin_addr_q;
  logic [3:0] smc_float_cycles, dram_float_cycles;
  logic [15:0] pullup_en_q;
  ebi_mux_pkg::smc_strobe_type smc_strobe;
  int fails, n_compared, seed, n;
  ebi_card_support_mux i_dut (.clk, .arst_n, .smc_haddr, .smc_rnw, .smc_addr, .smc_wdata, .smc_data_oe,
    .smc_strobe, .smc_float_cycles, .smc_busy, .dram_addr, .dram_wdata, .dram_data_oe, .dram_busy,
    .dram_float_cycles, .slot0_assign, .slot1_assign, .data_pullup_disable, .pin_data_in, .rdata_q,
    .pin_addr_q, .pin_data_out_q, .pin_data_oe_q, .pullup_en_q, .chip_select_4_q, .chip_select_5_q,
    .pin_read_q, .pin_write0_q, .pin_write1_q, .pin_write3_q, .card_enable_low_q, .card_enable_high_q,
    .smc_grant_q, .dram_grant_q);
  card_slot_model i_slot (.clk, .addr(pin_addr_q), .cs4_n(chip_select_4_q), .cs5_n(chip_select_5_q),
    .oe(pin_data_oe_q), .pullup_en(pullup_en_q), .data(pin_data_in));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("fails %0d compared %0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic grant_wait(input logic want_dram, output int k);
    k = 0;
    while ((want_dram ? dram_grant_q : smc_grant_q) !== 1'h1 && k < 40) begin
      @(negedge clk);
      k++;
    end
    if (k == 40) begin
      fails++;
      wrap_up();
    end
  endtask
  task automatic acc(input logic [3:0] win, input logic [2:0] md, input logic s0, input logic s1);
    logic [9:0] r;
    logic a, c, mem, io, ide, sel, e1, e2;
    logic [25:0] ea;
    ebi_mux_pkg::smc_strobe_type s;
    r = 10'($random(seed));
    s = {2'h3, r[7:0], 1'h0, r[8]};
    a = win == 4'h5 ? s0 : s1;
    c = a && md != 3'h1 && md != 3'h3 && md != 3'h5;
    mem = c && !md[2];
    io = c && md == 3'h4;
    ide = c && md[2:1] == 2'h3;
    sel = c || !a;
    if (!c) {e2, e1} = 2'h3;
    else if (md == 3'h7) {e2, e1} = 2'h1;
    else if (md == 3'h0 || (s.byte_mode && s.bus_width_field == ebi_mux_pkg::DBW_16)) begin
      {e2, e1} = {s.byte_sel_high, s.byte_sel_low};
    end
    else {e2, e1} = 2'h2;
    @(posedge clk);
    slot0_assign <= s0;
    slot1_assign <= s1;
    smc_haddr <= {win, 4'h0, md, 21'h0};
    smc_addr <= 26'($random(seed));
    smc_wdata <= $random(seed);
    smc_rnw <= r[9];
    smc_data_oe <= !r[9];
    smc_strobe <= s;
    smc_busy <= 1'h1;
    @(posedge clk);
    smc_strobe.cs4_n <= win != 4'h5;
    smc_strobe.cs5_n <= win != 4'h6;
    repeat (7) @(posedge clk);
    @(negedge clk);
    ea = smc_addr;
    if (ide) ea[22] = 1'h1;
    if (c) ea[25] = smc_rnw;
    chk("enables", {card_enable_high_q, card_enable_low_q}, {e2, e1});
    chk("oe_pin", pin_read_q, c && !mem ? io : s.read_strobe_n);
    chk("we_pin", pin_write0_q, c && !mem ? 1'h1 : s.write_enable_n);
    chk("ior_pin", pin_write1_q, c ? mem | s.read_strobe_n : s.byte_mode ? s[6] : s.write_strobe1_n);
    chk("iow_pin", pin_write3_q, c ? mem | s.write_enable_n : s.byte_mode ? s[3] : s.write_strobe3_n);
    chk("addr", pin_addr_q, ea);
    chk("cs_pins", {chip_select_4_q, chip_select_5_q}, {!(sel && win == 4'h5), !(sel && win == 4'h6)});
    chk("data_oe", pin_data_oe_q, !r[9]);
    if (!r[9]) chk("wdata", pin_data_out_q, smc_wdata);
    if (sel && r[9]) chk("rdata", rdata_q, {4{smc_addr[7:0] ^ 8'h5A}});
    @(posedge clk);
    smc_haddr[23:21] <= ~md;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("enables_hold", {card_enable_high_q, card_enable_low_q}, {e2, e1});
    @(posedge clk);
    smc_strobe.cs4_n <= 1'h1;
    smc_strobe.cs5_n <= 1'h1;
    @(posedge clk);
    smc_busy <= 1'h0;
    repeat (8) @(posedge clk);
  endtask
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  initial begin
    seed = 71;
    fails = 0;
    n_compared = 0;
    arst_n = 1'h0;
    {smc_haddr, smc_rnw, smc_addr, smc_wdata, smc_data_oe, smc_busy} = '0;
    {dram_addr, dram_wdata, dram_data_oe, dram_busy, slot0_assign, slot1_assign, data_pullup_disable} = '0;
    smc_strobe = '1;
    smc_float_cycles = 4'h2;
    dram_float_cycles = 4'h3;
    repeat (6) @(posedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    chk("pullup", pullup_en_q, 16'hFFFF);
    chk("idle", {card_enable_high_q, card_enable_low_q, chip_select_4_q, chip_select_5_q, smc_grant_q}, 5'h1E);
    @(posedge clk);
    data_pullup_disable <= 1'h1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("pullup_off", pullup_en_q, 16'h0000);
    @(posedge clk);
    data_pullup_disable <= 1'h0;
    for (int i = 0; i < 32; i++) acc(i[3] ? 4'h6 : 4'h5, i[2:0], i < 16 || i[0], i < 16 || i[1]);
    @(posedge clk);
    dram_addr <= 26'($random(seed));
    dram_wdata <= $random(seed);
    dram_data_oe <= 1'h1;
    dram_busy <= 1'h1;
    grant_wait(1'h1, n);
    @(negedge clk);
    chk("dram_addr", pin_addr_q, dram_addr);
    chk("dram_data", {pin_data_oe_q, pin_data_out_q}, {1'h1, dram_wdata});
    chk("smc_pins_off", {pin_read_q, pin_write0_q, chip_select_4_q}, 3'h7);
    @(posedge clk);
    dram_busy <= 1'h0;
    smc_busy <= 1'h1;
    grant_wait(1'h0, n);
    chk("float_wait", n > dram_float_cycles, 1'h1);
    @(posedge clk);
    dram_busy <= 1'h1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("refresh_no_stall", {smc_grant_q, dram_grant_q}, 2'h2);
    @(posedge clk);
    smc_busy <= 1'h0;
    grant_wait(1'h1, n);
    @(posedge clk);
    dram_busy <= 1'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'h0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("reset_mid", {pin_addr_q, dram_grant_q, pin_data_oe_q, card_enable_low_q}, {26'h0, 3'h1});
    @(posedge clk);
    arst_n <= 1'h1;
    @(negedge clk);
    chk("pullup_mid", pullup_en_q, 16'hFFFF);
    repeat (2) @(posedge clk);
    wrap_up();
  end
endmodule
